// ---- dv/arss_motor_model.sv ----
// Motor and load model seen from the drive outputs
`timescale 1ns/1ps
module arss_motor_model #(
  parameter int unsigned SETTLE = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Drive commands
  input wire logic drive_enable,
  input wire logic volt_raise,
  input wire logic freq_lower,
  // Load condition from the bench
  input wire logic heavy,
  // Feedback to the control core
  output logic [8:0] out_current_pct,
  output logic vf_restored
);
  int unsigned raise_cnt;
  // A coasting load draws high current until the frequency drops to its speed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_current_pct <= 9'h000;
      raise_cnt <= 0;
      vf_restored <= 1'b0;
    end else begin
      if (!drive_enable) begin
        out_current_pct <= heavy ? 9'h096 : 9'h028;
      end else if (freq_lower) begin
        out_current_pct <= out_current_pct - 9'h005;
      end
      raise_cnt <= (drive_enable && volt_raise) ? raise_cnt + 1 : 0;
      vf_restored <= drive_enable && volt_raise && raise_cnt >= SETTLE;
    end
  end
endmodule : arss_motor_model

// ---- dv/arss_top_sva.sv ----
// Port checker of the restart sequencer
`timescale 1ns/1ps
module arss_top_chk #(
  parameter int unsigned RIDE_CYCLES = 20
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Observed pins
  input wire logic power_ok,
  input wire logic [8:0] out_current_pct,
  input wire logic drive_enable,
  input wire logic volt_raise,
  input wire logic freq_lower,
  input wire logic accel_to_ref,
  input wire logic [15:0] restart_freq_ref,
  input wire logic [7:0] search_current_level,
  input wire logic second_motor_param_set,
  input wire logic motor1_enable,
  input wire logic motor2_enable,
  input wire logic status_relay_contacts
);
  logic [31:0] lo_cnt;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Margin covers the pin filter and the registered output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_cnt <= 32'h0;
    end else if (power_ok) begin
      lo_cnt <= 32'h0;
    end else if (lo_cnt != 32'hFFFFFFFF) begin
      lo_cnt <= lo_cnt + 32'h1;
    end
  end
  sequence s_search;
    drive_enable && !accel_to_ref;
  endsequence
  sequence s_search_held;
    s_search ##1 s_search;
  endsequence
  a_freq_lower_cause: assert property (freq_lower |-> $past(out_current_pct) > {1'b0, $past(search_current_level)})
    else $error("freq_lower without high current");
  a_volt_raise_cause: assert property (volt_raise |-> $past(out_current_pct) <= {1'b0, $past(search_current_level)})
    else $error("volt_raise with high current");
  a_search_cmd_excl: assert property (freq_lower |-> !volt_raise && drive_enable)
    else $error("search commands overlap");
  a_relay_in_search: assert property (status_relay_contacts |-> s_search)
    else $error("relay high outside search");
  a_relay_release: assert property (accel_to_ref |-> !status_relay_contacts)
    else $error("relay held during acceleration");
  a_one_motor: assert property (!(motor1_enable && motor2_enable))
    else $error("both motors enabled");
  a_motor2_set: assert property (motor2_enable |-> second_motor_param_set && drive_enable)
    else $error("motor2 without second set");
  a_uv_drive_off: assert property (lo_cnt > RIDE_CYCLES + 10 |-> !drive_enable)
    else $error("drive on after power loss");
  a_search_ref_hold: assert property (s_search_held |-> $stable(restart_freq_ref))
    else $error("reference moved during search");
endmodule : arss_top_chk

bind arss_top arss_top_chk #(.RIDE_CYCLES(RIDE_CYCLES)) arss_top_chk_inst (.pclk(pclk), .presetn(presetn),
  .power_ok(power_ok), .out_current_pct(out_current_pct), .drive_enable(drive_enable), .volt_raise(volt_raise),
  .freq_lower(freq_lower), .accel_to_ref(accel_to_ref), .restart_freq_ref(restart_freq_ref),
  .search_current_level(search_current_level), .second_motor_param_set(second_motor_param_set),
  .motor1_enable(motor1_enable), .motor2_enable(motor2_enable), .status_relay_contacts(status_relay_contacts));

// ---- dv/tb.sv ----
// Directed bench of the restart sequencer
`timescale 1ns/1ps
`include "arss_cfg.svh"
module tb;
  localparam int unsigned TICK = 10;
  localparam int unsigned RIDE = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic run_cmd, manual_reset, power_ok, estop, overheat, hw_fault, fault_trip, vf_restored, heavy;
  logic [4:0] mf_in;
  logic [8:0] cur;
  logic [7:0] lvl;
  logic [15:0] freq_ref, rref;
  logic drive_enable, volt_raise, freq_lower, accel_to_ref, carrier_out, m2_sel, m1_en, m2_en, relay, irq;
  int failures, cmp_count, n, p;
  wire [4:0] mon = {carrier_out, freq_lower, relay, drive_enable, accel_to_ref};

  arss_top #(.TICK_CYCLES(TICK), .RIDE_CYCLES(RIDE)) arss_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd), .manual_reset(manual_reset), .power_ok(power_ok),
    .emergency_stop_input(estop), .overheat(overheat), .hw_diag_fault(hw_fault), .mf_in(mf_in),
    .fault_trip(fault_trip), .out_current_pct(cur), .vf_restored(vf_restored), .freq_ref(freq_ref),
    .drive_enable(drive_enable), .volt_raise(volt_raise), .freq_lower(freq_lower), .accel_to_ref(accel_to_ref),
    .restart_freq_ref(rref), .search_current_level(lvl), .search_prop_gain(), .search_integral_gain(),
    .carrier_out(carrier_out), .second_motor_param_set(m2_sel), .motor1_enable(m1_en), .motor2_enable(m2_en),
    .status_relay_contacts(relay), .output2(), .irq(irq));
  arss_motor_model arss_motor_model_inst (.pclk(pclk), .presetn(presetn), .drive_enable(drive_enable),
    .volt_raise(volt_raise), .freq_lower(freq_lower), .heavy(heavy), .out_current_pct(cur),
    .vf_restored(vf_restored));

  task automatic final_report();
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
      if (k > 50) begin
        chk("pready", 1, 0);
        final_report();
      end
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, q & m);
  endtask : rd
  task automatic wait_bit(input int i, input logic v, input int lim);
    n = 0;
    while (mon[i] !== v) begin
      @(posedge pclk);
      n++;
      if (n > lim) begin
        chk("wait", 1, 0);
        final_report();
      end
    end
  endtask : wait_bit
  task automatic trip();
    @(posedge pclk);
    fault_trip <= 1'b1;
    @(posedge pclk);
    fault_trip <= 1'b0;
    wait_bit(1, 1'b0, 5);
  endtask : trip
  task automatic mreset();
    manual_reset <= 1'b1;
    repeat (6) @(posedge pclk);
    manual_reset <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : mreset
  task automatic auto_restart(input logic [3:0] left);
    trip();
    freq_ref <= 16'h0ABC;
    wait_bit(1, 1'b1, 400);
    chk("restart delay", 1, n >= 2 * TICK && n <= 2 * TICK + 10);
    chk("relay", 1, relay);
    chk("held ref", 16'h5555, rref);
    wait_bit(3, 1'b1, 20);
    wait_bit(0, 1'b1, 300);
    chk("relay off", 0, relay);
    rd(`ARSS_OFF_STATUS, 32'hF7, {24'h0, left, 4'h1}, "retries left");
    freq_ref <= 16'h5555;
  endtask : auto_restart

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    {psel, penable, pwrite, run_cmd, manual_reset, estop, overheat, hw_fault, fault_trip} = '0;
    {power_ok, heavy} = 2'b11;
    mf_in = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    freq_ref = 16'h1234;
    presetn = 1'b0;
    failures = 0;
    cmp_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ARSS_OFF_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl");
    rd(`ARSS_OFF_GAIN, 32'h3FFF3FFF, 32'h03E801F4, "gains");
    rd(`ARSS_OFF_RESTART, 32'h03FF000F, 32'h000A0000, "restart");
    rd(`ARSS_OFF_CARRIER, 32'hFF, 32'h1E, "carrier");
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped", 1, e);
    apb(1'b1, `ARSS_OFF_RESTART, 32'h0002000F);
    rd(`ARSS_OFF_RESTART, 32'h03FF000F, 32'h0002000A, "retry clamp");
    apb(1'b1, `ARSS_OFF_RESTART, 32'h00020002);
    apb(1'b1, `ARSS_OFF_CTRL, 32'h16);
    apb(1'b1, `ARSS_OFF_OUTFN, 32'h0F0F);
    apb(1'b1, `ARSS_OFF_IRQ_MASK, 32'hF);
    apb(1'b1, `ARSS_OFF_SEARCH, 32'h78);
    chk("level out", 8'h78, lvl);
    run_cmd <= 1'b1;
    freq_ref <= 16'h5555;
    wait_bit(0, 1'b1, 200);
    auto_restart(4'h1);
    auto_restart(4'h0);
    rd(`ARSS_OFF_IRQ_STAT, 32'hF, 32'hF, "irq status");
    chk("irq", 1, irq);
    apb(1'b1, `ARSS_OFF_IRQ_STAT, 32'hF);
    rd(`ARSS_OFF_IRQ_STAT, 32'hF, 32'h0, "irq clear");
    apb(1'b1, `ARSS_OFF_IRQ_MASK, 32'h0);
    trip();
    p = 0;
    repeat (100) begin
      @(posedge pclk);
      p += drive_enable;
    end
    chk("no retry", 0, p);
    chk("irq masked", 0, irq);
    apb(1'b1, `ARSS_OFF_IRQ_MASK, 32'hF);
    mreset();
    rd(`ARSS_OFF_STATUS, 32'hF0, 32'h20, "manual reload");
    wait_bit(0, 1'b1, 300);
    auto_restart(4'h1);
    repeat (3100) @(posedge pclk);
    rd(`ARSS_OFF_STATUS, 32'hF0, 32'h20, "quiet reload");
    for (int i = 0; i < 3; i++) begin
      {hw_fault, overheat, estop} <= 3'b001 << i;
      wait_bit(1, 1'b0, 20);
      repeat (60) @(posedge pclk);
      rd(`ARSS_OFF_STATUS, 32'h1FF, 32'h02B, "hard trip");
      {hw_fault, overheat, estop} <= 3'b000;
      mreset();
      wait_bit(0, 1'b1, 300);
    end
    power_ok <= 1'b0;
    repeat (10) @(posedge pclk);
    power_ok <= 1'b1;
    repeat (40) @(posedge pclk);
    chk("ride through", 1, drive_enable);
    power_ok <= 1'b0;
    repeat (RIDE + 20) @(posedge pclk);
    chk("uv off", 0, drive_enable);
    rd(`ARSS_OFF_STATUS, 32'h7, 32'h5, "uv state");
    power_ok <= 1'b1;
    wait_bit(0, 1'b1, 300);
    run_cmd <= 1'b0;
    wait_bit(1, 1'b0, 50);
    apb(1'b1, `ARSS_OFF_INFN, 32'h3000);
    mf_in <= 5'h04;
    repeat (10) @(posedge pclk);
    chk("second set", 1, m2_sel);
    run_cmd <= 1'b1;
    wait_bit(0, 1'b1, 300);
    chk("motor pair", 2'b10, {m2_en, m1_en});
    apb(1'b1, `ARSS_OFF_CARRIER, 32'h96);
    wait_bit(4, 1'b0, 20000);
    wait_bit(4, 1'b1, 20000);
    wait_bit(4, 1'b0, 20000);
    p = n;
    wait_bit(4, 1'b1, 20000);
    p += n;
    q = 32'((64'h1 << 32) / (`ARSS_NCO_STEP * 150));
    chk("carrier period", 1, p + 3 >= q && p <= q + 3);
    final_report();
  end
endmodule : tb

// ---- logic/arss_cfg.svh ----
// Offsets, reset values and timing constants of the restart sequencer
`ifndef ARSS_CFG_SVH
`define ARSS_CFG_SVH

`define ARSS_CLK_HZ 200000000
`define ARSS_TICK_MS 100
`define ARSS_TICK_CYCLES (`ARSS_CLK_HZ / 1000 * `ARSS_TICK_MS)
`define ARSS_RIDE_US 15000
`define ARSS_RIDE_CYCLES (`ARSS_CLK_HZ / 1000000 * `ARSS_RIDE_US)
`define ARSS_WATCH_S 30
`define ARSS_WATCH_TICKS (`ARSS_WATCH_S * 1000 / `ARSS_TICK_MS)
`define ARSS_NCO_STEP ((64'h1 << 32) * 100 / `ARSS_CLK_HZ)

`define ARSS_OFF_CTRL 12'h000
`define ARSS_OFF_SEARCH 12'h004
`define ARSS_OFF_GAIN 12'h008
`define ARSS_OFF_OUTFN 12'h00C
`define ARSS_OFF_INFN 12'h010
`define ARSS_OFF_RESTART 12'h014
`define ARSS_OFF_CARRIER 12'h018
`define ARSS_OFF_STATUS 12'h01C
`define ARSS_OFF_IRQ_STAT 12'h020
`define ARSS_OFF_IRQ_MASK 12'h024

`define ARSS_SEL_ACCEL 0
`define ARSS_SEL_FAULT 1
`define ARSS_SEL_POWER 2
`define ARSS_SEL_PON 3

`define ARSS_FN_SEARCH 5'h0F
`define ARSS_FN_MOTOR2 5'h0C
`define ARSS_RST_OUTFN 5'h0C
`define ARSS_RST_CURLVL 8'h64
`define ARSS_MIN_CURLVL 8'h50
`define ARSS_MAX_CURLVL 8'hC8
`define ARSS_RST_PGAIN 14'h01F4
`define ARSS_RST_IGAIN 14'h03E8
`define ARSS_MAX_GAIN 14'h270F
`define ARSS_RST_RETRY 4'h0
`define ARSS_MAX_RETRY 4'hA
`define ARSS_RST_DELAY 10'h00A
`define ARSS_MAX_DELAY 10'h258
`define ARSS_RST_CARRIER 8'h1E
`define ARSS_MIN_CARRIER 8'h0A
`define ARSS_MAX_CARRIER 8'h96

`define ARSS_IRQ_TRIP 0
`define ARSS_IRQ_RESTART 1
`define ARSS_IRQ_SEARCH_DONE 2
`define ARSS_IRQ_EXHAUSTED 3

`endif

// ---- logic/arss_pkg.sv ----
// Types of the restart sequencer
package arss_pkg;

  typedef enum logic [2:0] {
    ARSS_OFF, ARSS_RUN, ARSS_SEARCH, ARSS_TRIP, ARSS_DELAY, ARSS_UV
  } arss_state_t;

  typedef struct packed {
    logic [10:0] s1;
    logic [10:0] s2;
    logic [10:0] s3;
    logic [10:0] filt;
    arss_state_t st;
    logic first_start;
    logic [3:0] sel_bits;
    logic rst_en;
    logic pon_en;
    logic [7:0] cur_lvl;
    logic [13:0] pgain;
    logic [13:0] igain;
    logic [4:0] relay_fn;
    logic [4:0] out2_fn;
    logic [24:0] in_fn;
    logic [3:0] retry_cfg;
    logic [3:0] retry_left;
    logic [9:0] delay_cfg;
    logic [7:0] carrier_cfg;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [31:0] tick_cnt;
    logic [9:0] delay_ticks;
    logic [8:0] watch_ticks;
    logic watch_on;
    logic [31:0] ride_cnt;
    logic no_auto;
    logic [31:0] nco;
    logic motor2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic drive_en;
    logic volt_raise;
    logic freq_lower;
    logic accel_ref;
    logic relay_out;
    logic out2;
    logic [15:0] hold_ref;
  } arss_state_s_t;

endpackage : arss_pkg

// ---- logic/arss_top.sv ----
// Auto restart and speed search sequencer with carrier and second motor select
`timescale 1ns/1ps
`include "arss_cfg.svh"

module arss_top #(
  parameter int unsigned TICK_CYCLES = `ARSS_TICK_CYCLES,
  parameter int unsigned RIDE_CYCLES = `ARSS_RIDE_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External sequence pins
  input wire logic run_cmd,
  input wire logic manual_reset,
  input wire logic power_ok,
  input wire logic emergency_stop_input,
  input wire logic overheat,
  input wire logic hw_diag_fault,
  input wire logic [4:0] mf_in,
  // Control core, same clock
  input wire logic fault_trip,
  input wire logic [8:0] out_current_pct,
  input wire logic vf_restored,
  input wire logic [15:0] freq_ref,
  // Drive commands
  output logic drive_enable,
  output logic volt_raise,
  output logic freq_lower,
  output logic accel_to_ref,
  output logic [15:0] restart_freq_ref,
  output logic [7:0] search_current_level,
  output logic [13:0] search_prop_gain,
  output logic [13:0] search_integral_gain,
  output logic carrier_out,
  output logic second_motor_param_set,
  output logic motor1_enable,
  output logic motor2_enable,
  // Status relay and interrupt
  output logic status_relay_contacts,
  output logic output2,
  output logic irq
);

  arss_pkg::arss_state_s_t r;
  arss_pkg::arss_state_s_t next_r;

  // Filtered pins: index 10 run, 9 manual reset, 8 power, 7 estop, 6 overheat, 5 hw diag, 4:0 mf
  logic f_run;
  logic f_rst;
  logic f_pwr;
  logic rst_rise;
  logic m2_req;
  logic cur_high;
  logic any_fault;
  logic hard_fault;
  logic tick;
  logic wr;
  logic rd;
  logic [3:0] irq_set;
  logic [31:0] rdata;
  logic mapped;

  assign f_run = r.filt[10];
  assign f_rst = r.filt[9];
  assign f_pwr = r.filt[8];
  assign hard_fault = r.filt[7] | r.filt[6] | r.filt[5];
  assign any_fault = fault_trip | hard_fault;
  assign cur_high = out_current_pct > {1'b0, r.cur_lvl};
  assign tick = r.tick_cnt == TICK_CYCLES - 1;
  assign wr = psel & penable & pwrite & r.pready;
  assign rd = psel & penable & ~r.pready;

  always_comb begin
    logic [9:0] dly;
    logic [3:0] rty;
    logic [7:0] lvl;
    logic [7:0] car;
    logic [13:0] pg;
    logic [13:0] ig;
    logic [4:0] code;
    code = 5'h00;
    dly = pwdata[25:16];
    rty = pwdata[3:0];
    lvl = pwdata[7:0];
    car = pwdata[7:0];
    pg = pwdata[13:0];
    ig = pwdata[29:16];
    rst_rise = 1'b0;
    m2_req = 1'b0;
    for (int i = 0; i < 5; i++) begin
      code = r.in_fn[i*5 +: 5];
      if (code == `ARSS_FN_MOTOR2 && r.filt[i]) begin
        m2_req = 1'b1;
      end
    end
    next_r = r;
    irq_set = 4'h0;

    // Three stage pin capture; a change counts once stages two and three agree
    next_r.s1 = {run_cmd, manual_reset, power_ok, emergency_stop_input, overheat, hw_diag_fault, mf_in};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < 11; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.filt[i] = r.s3[i];
      end
    end
    rst_rise = r.s2[9] & r.s3[9] & ~f_rst;

    next_r.tick_cnt = tick ? 32'h0 : r.tick_cnt + 32'h1;
    next_r.nco = r.nco + 32'(r.carrier_cfg * `ARSS_NCO_STEP);

    // Ride-through timer on input power
    if (f_pwr) begin
      next_r.ride_cnt = 32'h0;
    end else if (r.ride_cnt < RIDE_CYCLES) begin
      next_r.ride_cnt = r.ride_cnt + 32'h1;
    end

    // Retry reload after a clean run following an auto restart
    if (r.watch_on && tick) begin
      if (r.watch_ticks == 9'(`ARSS_WATCH_TICKS - 1)) begin
        next_r.watch_on = 1'b0;
        next_r.retry_left = r.retry_cfg;
      end else begin
        next_r.watch_ticks = r.watch_ticks + 9'h1;
      end
    end

    unique case (r.st)
      arss_pkg::ARSS_OFF: begin
        if (f_run && f_pwr) begin
          next_r.first_start = 1'b0;
          if ((r.first_start && r.pon_en && r.sel_bits[`ARSS_SEL_PON]) || r.sel_bits[`ARSS_SEL_ACCEL]) begin
            next_r.st = arss_pkg::ARSS_SEARCH;
          end else begin
            next_r.st = arss_pkg::ARSS_RUN;
          end
        end
      end
      arss_pkg::ARSS_RUN, arss_pkg::ARSS_SEARCH: begin
        if (r.ride_cnt >= RIDE_CYCLES) begin
          next_r.st = arss_pkg::ARSS_UV;
          next_r.hold_ref = freq_ref;
          next_r.watch_on = 1'b0;
          irq_set[`ARSS_IRQ_TRIP] = 1'b1;
        end else if (any_fault) begin
          next_r.st = arss_pkg::ARSS_TRIP;
          next_r.no_auto = hard_fault;
          next_r.hold_ref = freq_ref;
          next_r.watch_on = 1'b0;
          irq_set[`ARSS_IRQ_TRIP] = 1'b1;
        end else if (!f_run) begin
          next_r.st = arss_pkg::ARSS_OFF;
        end else if (r.st == arss_pkg::ARSS_SEARCH && vf_restored && !cur_high) begin
          next_r.st = arss_pkg::ARSS_RUN;
          irq_set[`ARSS_IRQ_SEARCH_DONE] = 1'b1;
        end else if (r.st == arss_pkg::ARSS_RUN) begin
          next_r.hold_ref = freq_ref;
        end
      end
      arss_pkg::ARSS_TRIP: begin
        if (rst_rise) begin
          next_r.retry_left = r.retry_cfg;
          if (f_run && r.rst_en && r.sel_bits[`ARSS_SEL_FAULT]) begin
            next_r.st = arss_pkg::ARSS_SEARCH;
          end else begin
            next_r.st = arss_pkg::ARSS_OFF;
          end
        end else if (f_run && !r.no_auto && r.retry_left != 4'h0) begin
          // The tick divider restarts here so that the delay is never cut short by a partial first tick.
          // The watch timer shares the divider, but any trip has already cancelled it.
          next_r.st = arss_pkg::ARSS_DELAY;
          next_r.delay_ticks = 10'h0;
          next_r.tick_cnt = 32'h0;
        end
      end
      arss_pkg::ARSS_DELAY: begin
        if (rst_rise) begin
          next_r.retry_left = r.retry_cfg;
          next_r.st = arss_pkg::ARSS_OFF;
        end else if (!f_run) begin
          next_r.st = arss_pkg::ARSS_TRIP;
        end else if (r.delay_ticks >= r.delay_cfg) begin
          // Auto restart always re-catches the motor through the search
          next_r.st = arss_pkg::ARSS_SEARCH;
          next_r.retry_left = r.retry_left - 4'h1;
          next_r.watch_on = 1'b1;
          next_r.watch_ticks = 9'h0;
          irq_set[`ARSS_IRQ_RESTART] = 1'b1;
          if (r.retry_left == 4'h1) begin
            irq_set[`ARSS_IRQ_EXHAUSTED] = 1'b1;
          end
        end else if (tick) begin
          next_r.delay_ticks = r.delay_ticks + 10'h1;
        end
      end
      arss_pkg::ARSS_UV: begin
        if (f_pwr) begin
          if (f_run && r.sel_bits[`ARSS_SEL_POWER]) begin
            next_r.st = arss_pkg::ARSS_SEARCH;
          end else begin
            next_r.st = arss_pkg::ARSS_OFF;
          end
        end
      end
    endcase

    // Motor select is only taken while the drive is stopped
    if (next_r.st != arss_pkg::ARSS_RUN && next_r.st != arss_pkg::ARSS_SEARCH &&
        r.st != arss_pkg::ARSS_RUN && r.st != arss_pkg::ARSS_SEARCH) begin
      next_r.motor2 = m2_req;
    end

    next_r.drive_en = next_r.st == arss_pkg::ARSS_RUN || next_r.st == arss_pkg::ARSS_SEARCH;
    next_r.volt_raise = next_r.st == arss_pkg::ARSS_SEARCH && !cur_high;
    next_r.freq_lower = next_r.st == arss_pkg::ARSS_SEARCH && cur_high;
    next_r.accel_ref = next_r.st == arss_pkg::ARSS_RUN;
    next_r.relay_out = next_r.st == arss_pkg::ARSS_SEARCH && r.relay_fn == `ARSS_FN_SEARCH;
    next_r.out2 = next_r.st == arss_pkg::ARSS_SEARCH && r.out2_fn == `ARSS_FN_SEARCH;

    // APB: one wait state, answer registered
    mapped = 1'b1;
    unique case (paddr)
      `ARSS_OFF_CTRL: rdata = {26'h0, r.pon_en, r.rst_en, r.sel_bits};
      `ARSS_OFF_SEARCH: rdata = {24'h0, r.cur_lvl};
      `ARSS_OFF_GAIN: rdata = {2'h0, r.igain, 2'h0, r.pgain};
      `ARSS_OFF_OUTFN: rdata = {19'h0, r.out2_fn, 3'h0, r.relay_fn};
      `ARSS_OFF_INFN: rdata = {7'h0, r.in_fn};
      `ARSS_OFF_RESTART: rdata = {6'h0, r.delay_cfg, 12'h0, r.retry_cfg};
      `ARSS_OFF_CARRIER: rdata = {24'h0, r.carrier_cfg};
      `ARSS_OFF_STATUS: rdata = {23'h0, r.motor2, r.retry_left, r.no_auto, r.st};
      `ARSS_OFF_IRQ_STAT: rdata = {28'h0, r.irq_stat};
      `ARSS_OFF_IRQ_MASK: rdata = {28'h0, r.irq_mask};
      default: begin
        rdata = 32'h0;
        mapped = 1'b0;
      end
    endcase
    next_r.pready = rd;
    next_r.pslverr = rd & ~mapped;
    next_r.prdata = (rd && !pwrite) ? rdata : 32'h0;

    // Out-of-range settings are clamped to their documented limits
    if (wr && mapped) begin
      unique case (paddr)
        `ARSS_OFF_CTRL: begin
          next_r.sel_bits = pwdata[3:0];
          next_r.rst_en = pwdata[4];
          next_r.pon_en = pwdata[5];
        end
        `ARSS_OFF_SEARCH: begin
          next_r.cur_lvl = lvl < `ARSS_MIN_CURLVL ? `ARSS_MIN_CURLVL :
                           lvl > `ARSS_MAX_CURLVL ? `ARSS_MAX_CURLVL : lvl;
        end
        `ARSS_OFF_GAIN: begin
          next_r.pgain = pg > `ARSS_MAX_GAIN ? `ARSS_MAX_GAIN : pg;
          next_r.igain = ig > `ARSS_MAX_GAIN ? `ARSS_MAX_GAIN : ig;
        end
        `ARSS_OFF_OUTFN: begin
          next_r.relay_fn = pwdata[4:0];
          next_r.out2_fn = pwdata[12:8];
        end
        `ARSS_OFF_INFN: next_r.in_fn = pwdata[24:0];
        `ARSS_OFF_RESTART: begin
          next_r.retry_cfg = rty > `ARSS_MAX_RETRY ? `ARSS_MAX_RETRY : rty;
          next_r.retry_left = rty > `ARSS_MAX_RETRY ? `ARSS_MAX_RETRY : rty;
          next_r.delay_cfg = dly > `ARSS_MAX_DELAY ? `ARSS_MAX_DELAY : dly;
        end
        `ARSS_OFF_CARRIER: begin
          next_r.carrier_cfg = car < `ARSS_MIN_CARRIER ? `ARSS_MIN_CARRIER :
                               car > `ARSS_MAX_CARRIER ? `ARSS_MAX_CARRIER : car;
        end
        `ARSS_OFF_IRQ_MASK: next_r.irq_mask = pwdata[3:0];
        default: ;
      endcase
    end

    // Sticky events: a new event wins over a write-one-to-clear in the same cycle
    next_r.irq_stat = (r.irq_stat & ~((wr && paddr == `ARSS_OFF_IRQ_STAT) ? pwdata[3:0] : 4'h0)) | irq_set;
    next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
  end

  // Single state register; pins reset to zero, so power reads as lost until the filter has settled.
  // That is harmless while stopped, since the ride-through timer only matters in run or search.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= arss_pkg::ARSS_OFF;
      r.first_start <= 1'b1;
      r.cur_lvl <= `ARSS_RST_CURLVL;
      r.pgain <= `ARSS_RST_PGAIN;
      r.igain <= `ARSS_RST_IGAIN;
      r.relay_fn <= `ARSS_RST_OUTFN;
      r.out2_fn <= `ARSS_RST_OUTFN;
      r.retry_cfg <= `ARSS_RST_RETRY;
      r.retry_left <= `ARSS_RST_RETRY;
      r.delay_cfg <= `ARSS_RST_DELAY;
      r.carrier_cfg <= `ARSS_RST_CARRIER;
    end else begin
      r <= next_r;
    end
  end

  // Every output except motor1_enable and motor2_enable is a straight copy of a state flop
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign drive_enable = r.drive_en;
  assign volt_raise = r.volt_raise;
  assign freq_lower = r.freq_lower;
  assign accel_to_ref = r.accel_ref;
  assign restart_freq_ref = r.hold_ref;
  assign search_current_level = r.cur_lvl;
  assign search_prop_gain = r.pgain;
  assign search_integral_gain = r.igain;
  assign carrier_out = r.nco[31];
  assign second_motor_param_set = r.motor2;
  // Both enables come from one flop pair so they can never be high together
  assign motor1_enable = r.drive_en & ~r.motor2 & ~r.accel_ref | r.accel_ref & ~r.motor2 & r.drive_en;
  assign motor2_enable = r.drive_en & r.motor2;
  assign status_relay_contacts = r.relay_out;
  assign output2 = r.out2;
  assign irq = r.irq;

endmodule : arss_top
